// ==== design/sar_adc_serial_readout.sv ====
// Purpose: serial readout of a 16-bit converter in chip-select mode
// Assumes: all pins sampled by ref_clk_i; result word from the converter core
// Notes: daisy-chain readout and register framing are not handled here
`timescale 1ns/10ps
module sar_adc_serial_readout (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic conv_strobe_i,
    input wire logic select_input_i,
    input wire logic sck_i,
    input wire logic overvoltage_i,
    input wire logic turbo_en_i,
    input wire logic status_en_i,
    input wire logic span_comp_i,
    input wire logic high_z_i,
    input wire logic [sar_pkg::RESULT_W-1:0] conv_result_i,
    output logic serial_out_o,
    output logic serial_out_oe_o,
    output logic converting_o,
    output logic conv_done_o,
    output logic powered_down_o,
    output logic cs_mode_o
);

    logic [sar_pkg::SYNC_W-1:0] pin_lvl;
    logic [sar_pkg::SYNC_W-1:0] pin_rise;
    logic [sar_pkg::SYNC_W-1:0] pin_fall;

    sar_pin_sync u_sync (
        .ref_clk_i(ref_clk_i),
        .arst_n_i(arst_n_i),
        .pin_i({overvoltage_i, sck_i, select_input_i, conv_strobe_i}),
        .level_o(pin_lvl),
        .rise_o(pin_rise),
        .fall_o(pin_fall)
    );

    logic stb_lvl;
    logic stb_rise;
    logic stb_fall;
    logic sel_lvl;
    logic sel_rise;
    logic sel_fall;
    logic sck_fall;
    logic overv_lvl;

    assign stb_lvl = pin_lvl[sar_pkg::PIN_STROBE];
    assign stb_rise = pin_rise[sar_pkg::PIN_STROBE];
    assign stb_fall = pin_fall[sar_pkg::PIN_STROBE];
    assign sel_lvl = pin_lvl[sar_pkg::PIN_SEL];
    assign sel_rise = pin_rise[sar_pkg::PIN_SEL];
    assign sel_fall = pin_fall[sar_pkg::PIN_SEL];
    assign sck_fall = pin_fall[sar_pkg::PIN_SCK];
    assign overv_lvl = pin_lvl[sar_pkg::PIN_OVERV];

    // ---------------- conversion sequencing ----------------
    sar_pkg::sar_conv_state_t conv_q;
    logic [sar_pkg::TMR_W-1:0] tmr_q;
    logic cs_mode_q;
    logic conv_start;
    logic conv_end;

    // a rising strobe during a conversion is ignored: it runs to completion
    assign conv_start = stb_rise && (conv_q == sar_pkg::CONV_ACQUIRE);
    assign conv_end = (conv_q == sar_pkg::CONV_RUN) && (tmr_q == '0);

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_q <= sar_pkg::CONV_ACQUIRE;
            tmr_q <= '0;
        end else begin
            case (conv_q)
                sar_pkg::CONV_ACQUIRE: begin
                    if (conv_start) begin
                        conv_q <= sar_pkg::CONV_RUN;
                        tmr_q <= sar_pkg::CONV_LOAD;
                    end
                end
                sar_pkg::CONV_RUN: begin
                    if (conv_end) begin
                        conv_q <= sar_pkg::CONV_ACQUIRE;
                    end else begin
                        tmr_q <= tmr_q - 1'b1;
                    end
                end
                default: begin
                    conv_q <= sar_pkg::CONV_ACQUIRE;
                end
            endcase
        end
    end

    // mode picked by the select level seen with the strobe edge
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_mode_q <= 1'b0;
        end else if (conv_start) begin
            cs_mode_q <= sel_lvl;
        end
    end

    // ---------------- result and status capture ----------------
    logic [sar_pkg::RESULT_W-1:0] result_q;
    logic [sar_pkg::STATUS_W-1:0] status_q;
    logic [sar_pkg::STATUS_W-1:0] status_now;

    // overvoltage is sampled at the end of each conversion, low means overvoltage
    assign status_now = {~overv_lvl, span_comp_i, high_z_i, turbo_en_i,
        sar_pkg::ST_RSVD};

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            result_q <= '0;
            status_q <= {sar_pkg::ST_OVFLAG_RESET, {(sar_pkg::STATUS_W-1){1'b0}}};
        end else if (conv_end) begin
            result_q <= conv_result_i;
            status_q <= status_now;
        end
    end

    // ---------------- serial frame ----------------
    sar_pkg::sar_rd_state_t rd_q;
    logic [sar_pkg::FRAME_W-1:0] sh_q;
    logic [sar_pkg::CNT_W-1:0] cnt_q;
    logic [sar_pkg::CNT_W-1:0] len_q;
    logic [sar_pkg::CNT_W-1:0] len_plain;
    logic want_busy;
    logic deselect;

    function automatic logic [sar_pkg::FRAME_W-1:0] frame_word(
        input logic busy,
        input logic [sar_pkg::RESULT_W-1:0] res,
        input logic [sar_pkg::STATUS_W-1:0] st
    );
        // busy frames lead with a low start bit, data follows without a gap
        if (busy) begin
            frame_word = {1'b0, res, st};
        end else begin
            frame_word = {res, st, 1'b0};
        end
    endfunction : frame_word

    assign len_plain = sar_pkg::FALLS_DATA
        + (status_en_i ? sar_pkg::FALLS_STATUS : sar_pkg::FALLS_NONE);
    // turbo blocks the busy start bit completely
    assign want_busy = cs_mode_q && !turbo_en_i && (!stb_lvl || !sel_lvl);
    // select rising ends any frame, covering the four-wire forms
    assign deselect = sel_rise;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rd_q <= sar_pkg::RD_FLOAT;
            sh_q <= '0;
            cnt_q <= '0;
            len_q <= '0;
        end else if (stb_rise) begin
            cnt_q <= '0;
            if (turbo_en_i && sel_lvl && conv_start) begin
                // previous result is readable while the new one converts
                rd_q <= sar_pkg::RD_ARMED;
                sh_q <= frame_word(1'b0, result_q, status_q);
                len_q <= len_plain;
            end else begin
                rd_q <= sar_pkg::RD_FLOAT;
            end
        end else if (deselect) begin
            rd_q <= sar_pkg::RD_FLOAT;
        end else if (conv_end && cs_mode_q && !turbo_en_i) begin
            cnt_q <= '0;
            if (want_busy) begin
                // output goes low as the completion signal
                rd_q <= sar_pkg::RD_DRIVE;
                sh_q <= frame_word(1'b1, conv_result_i, status_now);
                len_q <= len_plain + sar_pkg::FALLS_BUSY;
            end else begin
                rd_q <= sar_pkg::RD_ARMED;
                sh_q <= frame_word(1'b0, conv_result_i, status_now);
                len_q <= len_plain;
            end
        end else begin
            case (rd_q)
                sar_pkg::RD_FLOAT: begin
                    rd_q <= sar_pkg::RD_FLOAT;
                end
                sar_pkg::RD_ARMED: begin
                    if (stb_fall || sel_fall) begin
                        rd_q <= sar_pkg::RD_DRIVE;
                    end
                end
                sar_pkg::RD_DRIVE: begin
                    if (sck_fall) begin
                        if (cnt_q == len_q - 1'b1) begin
                            rd_q <= sar_pkg::RD_FLOAT;
                        end else begin
                            sh_q <= {sh_q[sar_pkg::FRAME_W-2:0], 1'b0};
                            cnt_q <= cnt_q + 1'b1;
                        end
                    end
                end
                default: begin
                    rd_q <= sar_pkg::RD_FLOAT;
                end
            endcase
        end
    end

    // bit changes only on a falling sck, so it stands through both edges
    assign serial_out_o = sh_q[sar_pkg::FRAME_W-1];
    assign serial_out_oe_o = (rd_q == sar_pkg::RD_DRIVE);
    assign converting_o = (conv_q == sar_pkg::CONV_RUN);
    assign powered_down_o = (conv_q == sar_pkg::CONV_ACQUIRE);
    assign cs_mode_o = cs_mode_q;

    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            conv_done_o <= 1'b0;
        end else begin
            conv_done_o <= conv_end;
        end
    end

    // ---------------- checks ----------------
    a_conv_length: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        conv_start |=> converting_o ##15 (converting_o && conv_end) ##1 !converting_o)
        else $error("conversion length wrong");

    a_conv_holds: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        conv_start |=> converting_o[*8])
        else $error("conversion stopped early");

    a_start_floats: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (stb_rise && !(turbo_en_i && sel_lvl && conv_start)) |=> !serial_out_oe_o)
        else $error("output not floated on strobe rise");

    a_busy_start: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (conv_end && want_busy && !stb_rise && !sel_rise)
        |=> serial_out_oe_o && !serial_out_o)
        else $error("busy start bit missing");

    a_quiet_conv: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (converting_o && !conv_end && !turbo_en_i && rd_q != sar_pkg::RD_DRIVE)
        |=> !serial_out_oe_o)
        else $error("output driven during conversion");

    a_turbo_nobusy: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (conv_end && turbo_en_i && rd_q == sar_pkg::RD_FLOAT && !stb_rise)
        |=> !serial_out_oe_o)
        else $error("busy bit in turbo");

    a_msb_on_fall: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (rd_q == sar_pkg::RD_ARMED && (stb_fall || sel_fall) && !stb_rise && !sel_rise
         && !conv_end)
        |=> serial_out_oe_o && serial_out_o == $past(sh_q[sar_pkg::FRAME_W-1]))
        else $error("msb not driven on select fall");

    a_frame_end: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (rd_q == sar_pkg::RD_DRIVE && sck_fall && cnt_q == len_q - 1'b1 && !stb_rise)
        |=> !serial_out_oe_o)
        else $error("frame did not end on last fall");

    a_select_float: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (sel_rise && !stb_rise) |=> !serial_out_oe_o)
        else $error("select rise did not float output");

    a_bit_stable: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        (serial_out_oe_o && !sck_fall && !stb_rise && !conv_end)
        |=> $stable(serial_out_o))
        else $error("data changed without sck fall");

    a_overv_refresh: assert property (@(posedge ref_clk_i) disable iff (!arst_n_i)
        conv_end |=> status_q[sar_pkg::ST_OVFLAG] == !$past(overv_lvl))
        else $error("overvoltage flag not refreshed");

endmodule : sar_adc_serial_readout

// ==== design/sar_pkg.sv ====
// Purpose: shared constants and types of the converter serial readout block
// Assumes: 50 MHz block clock; conversion timing is internal to the device
// Notes: frame counts are in falling edges of the serial clock
package sar_pkg;

    localparam int RESULT_W = 16;
    localparam int STATUS_W = 6;
    // one extra slot for the busy start bit
    localparam int FRAME_W = RESULT_W + STATUS_W + 1;
    localparam int CNT_W = 5;

    // status word field positions
    localparam int ST_OVFLAG = 5;
    localparam int ST_SPAN = 4;
    localparam int ST_HIGHZ = 3;
    localparam int ST_TURBO = 2;
    localparam logic [1:0] ST_RSVD = 2'h0;
    localparam logic ST_OVFLAG_RESET = 1'h1;

    // falling edges per frame section
    localparam logic [CNT_W-1:0] FALLS_DATA = 5'h10;
    localparam logic [CNT_W-1:0] FALLS_STATUS = 5'h06;
    localparam logic [CNT_W-1:0] FALLS_NONE = 5'h00;
    localparam logic [CNT_W-1:0] FALLS_BUSY = 5'h01;

    // internal conversion time
    localparam int CLK_PERIOD_NS = 20;
    localparam int CONV_TIME_NS = 320;
    localparam int CONV_CYC = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TMR_W = 5;
    localparam logic [TMR_W-1:0] CONV_LOAD = TMR_W'(CONV_CYC - 1);

    // synchronised pin bundle layout
    localparam int SYNC_W = 4;
    localparam int PIN_STROBE = 0;
    localparam int PIN_SEL = 1;
    localparam int PIN_SCK = 2;
    localparam int PIN_OVERV = 3;

    typedef enum logic {
        CONV_ACQUIRE,
        CONV_RUN
    } sar_conv_state_t;

    typedef enum logic [1:0] {
        RD_FLOAT,
        RD_ARMED,
        RD_DRIVE
    } sar_rd_state_t;

endpackage : sar_pkg

// ==== design/sar_pin_sync.sv ====
// Purpose: two-flop synchronisers with edge detection for the device pins
// Assumes: pins are asynchronous to ref_clk_i
// Notes: edges are found from the second and third stage only
`timescale 1ns/10ps
module sar_pin_sync (
    input wire logic ref_clk_i,
    input wire logic arst_n_i,
    input wire logic [sar_pkg::SYNC_W-1:0] pin_i,
    output logic [sar_pkg::SYNC_W-1:0] level_o,
    output logic [sar_pkg::SYNC_W-1:0] rise_o,
    output logic [sar_pkg::SYNC_W-1:0] fall_o
);

    genvar g;
    generate
        for (g = 0; g < sar_pkg::SYNC_W; g++) begin : g_pin
            logic meta_q;
            logic sync_q;
            logic prev_q;

            always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
                if (!arst_n_i) begin
                    meta_q <= 1'b0;
                    sync_q <= 1'b0;
                    prev_q <= 1'b0;
                end else begin
                    meta_q <= pin_i[g];
                    sync_q <= meta_q;
                    prev_q <= sync_q;
                end
            end

            assign level_o[g] = sync_q;
            assign rise_o[g] = sync_q & ~prev_q;
            assign fall_o[g] = ~sync_q & prev_q;
        end
    endgenerate

endmodule : sar_pin_sync

// ==== test/sar_host_model.sv ====
// Purpose: host model driving strobe, select and serial clock of the readout
// Assumes: pins change on falling edges of ref_clk_i
// Notes: waits are plain cycle counts; serial clock rests low between frames
`timescale 1ns/10ps
module sar_host_model #(
    parameter int QUIET_CYC = 6,
    parameter int HALF_CYC = 4
) (
    input wire logic ref_clk_i,
    input wire logic serial_out_i,
    output logic conv_strobe_o,
    output logic select_input_o,
    output logic sck_o
);
    initial begin
        conv_strobe_o = 1'h0;
        select_input_o = 1'h1;
        sck_o = 1'h0;
    end

    task automatic wait_cyc(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask : wait_cyc

    // every pin change is followed by a quiet gap before the next action
    task automatic pin(input logic s, input logic c);
        conv_strobe_o = s;
        select_input_o = c;
        wait_cyc(QUIET_CYC);
    endtask : pin

    // clock is only toggled here, never while a conversion runs
    task automatic read(input int n, output logic [22:0] d_r, output logic [22:0] d_f);
        d_r = '0;
        d_f = '0;
        for (int i = 0; i < n; i++) begin
            d_r = {d_r[21:0], serial_out_i};
            sck_o = 1'h1;
            wait_cyc(HALF_CYC);
            d_f = {d_f[21:0], serial_out_i};
            sck_o = 1'h0;
            wait_cyc(HALF_CYC);
        end
    endtask : read
endmodule : sar_host_model

// ==== test/tb_top.sv ====
// Purpose: self-checking bench of the converter serial readout
// Assumes: host model drives strobe, select and serial clock
// Notes: expected frames are built from the result and status settings
`timescale 1ns/10ps
module tb_top;
    logic clk;
    logic arst_n;
    logic strobe, sel, sck, overv, turbo, st_en, span, hz;
    logic [sar_pkg::RESULT_W-1:0] res;
    logic so, oe, conv, done, pd, cs;
    logic serial_out_w;
    int errors;
    int samples_checked;
    int cyc;

    // a released line shows the inverse, so a stale bit never passes
    assign serial_out_w = oe ? so : ~so;

    sar_adc_serial_readout u_sar_adc_serial_readout (
        .ref_clk_i(clk),
        .arst_n_i(arst_n),
        .conv_strobe_i(strobe),
        .select_input_i(sel),
        .sck_i(sck),
        .overvoltage_i(overv),
        .turbo_en_i(turbo),
        .status_en_i(st_en),
        .span_comp_i(span),
        .high_z_i(hz),
        .conv_result_i(res),
        .serial_out_o(so),
        .serial_out_oe_o(oe),
        .converting_o(conv),
        .conv_done_o(done),
        .powered_down_o(pd),
        .cs_mode_o(cs)
    );

    sar_host_model u_sar_host_model (
        .ref_clk_i(clk),
        .serial_out_i(serial_out_w),
        .conv_strobe_o(strobe),
        .select_input_o(sel),
        .sck_o(sck)
    );

    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic end_sim();
        if (errors == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : end_sim

    task automatic check(input logic [22:0] seen, input logic [22:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic pin(input logic s, input logic c);
        u_sar_host_model.pin(s, c);
    endtask : pin

    task automatic rd(input int n, input logic [22:0] exp);
        logic [22:0] r;
        logic [22:0] f;
        u_sar_host_model.read(n, r, f);
        check(r, exp);
        check(f, exp);
    endtask : rd

    task automatic wait_done();
        int n;
        n = 0;
        while (done !== 1'h1 && n < 40) begin
            @(negedge clk);
            n++;
        end
        check(done, 1'h1);
        check(pd, 1'h1);
        check(conv, 1'h0);
    endtask : wait_done

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            errors++;
            end_sim();
        end
    end

    initial begin
        arst_n = 1'h0;
        overv = 1'h0;
        turbo = 1'h0;
        st_en = 1'h0;
        span = 1'h0;
        hz = 1'h0;
        res = 16'hb5c3;
        repeat (4) @(negedge clk);
        check(oe, 1'h0);
        check(pd, 1'h1);
        arst_n = 1'h1;
        repeat (4) @(negedge clk);
        pin(1'h1, 1'h1);
        check(conv, 1'h1);
        check(oe, 1'h0);
        check(cs, 1'h1);
        wait_done();
        pin(1'h0, 1'h1);
        rd(16, res);
        check(oe, 1'h0);
        st_en = 1'h1;
        overv = 1'h1;
        span = 1'h1;
        res = 16'h5a3c;
        pin(1'h1, 1'h1);
        wait_done();
        pin(1'h0, 1'h1);
        rd(22, {res, 6'h10});
        check(oe, 1'h0);
        overv = 1'h0;
        pin(1'h1, 1'h1);
        wait_done();
        pin(1'h0, 1'h1);
        rd(18, {res, 2'h3});
        check(oe, 1'h1);
        pin(1'h1, 1'h1);
        check(conv, 1'h1);
        check(oe, 1'h0);
        wait_done();
        st_en = 1'h0;
        res = 16'ha53c;
        pin(1'h0, 1'h1);
        pin(1'h1, 1'h1);
        pin(1'h0, 1'h1);
        check(oe, 1'h0);
        wait_done();
        check(oe, 1'h1);
        check(so, 1'h0);
        rd(17, {1'h0, res});
        check(oe, 1'h0);
        turbo = 1'h1;
        res = 16'h96e1;
        pin(1'h1, 1'h1);
        pin(1'h0, 1'h1);
        wait_done();
        check(oe, 1'h1);
        check(so, 1'h1);
        rd(16, 16'ha53c);
        check(oe, 1'h0);
        res = 16'h0ff0;
        pin(1'h1, 1'h1);
        wait_done();
        pin(1'h1, 1'h0);
        check(so, 1'h1);
        rd(8, 8'h96);
        check(oe, 1'h1);
        pin(1'h1, 1'h1);
        check(oe, 1'h0);
        turbo = 1'h0;
        pin(1'h0, 1'h0);
        pin(1'h1, 1'h0);
        check(cs, 1'h0);
        wait_done();
        check(oe, 1'h0);
        end_sim();
    end
endmodule : tb_top
